// [rtl/operand_field_decoder.sv]
// operand field decoder: splits instruction words into datapath fields
// assumes words arrive on the core clock from fetch and an APB master
`timescale 1ns/1ns
`default_nettype none
module operand_field_decoder #(
   parameter logic [7:0] ACCESS_SPLIT = 8'h60
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic [15:0] INSTR_I,
   input  wire logic        INSTR_VALID_I,
   input  wire logic [4:0]  FLAG_UPD_I,
   input  wire logic [4:0]  FLAG_VAL_I,
   input  wire logic        LATCH_WE_I,
   input  wire logic [7:0]  LATCH_D_I,
   output logic             DEC_VALID_O,
   output logic      [3:0]  OP_CLASS_O,
   output logic      [11:0] DATA_ADDR_O,
   output logic             DEST_FILE_O,
   output logic      [2:0]  BIT_INDEX_O,
   output logic      [1:0]  PTR_SEL_O,
   output logic      [11:0] MOVE_SRC_O,
   output logic      [11:0] MOVE_DST_O,
   output logic      [19:0] LITERAL_O,
   output logic      [10:0] BRANCH_OFF_O,
   output logic             FAST_SHADOW_O,
   output logic      [6:0]  SRC_IDX_O,
   output logic      [6:0]  DST_IDX_O,
   output logic      [20:0] TBL_ADDR_O,
   output logic             TBL_WRITE_O,
   output logic      [1:0]  EXEC_CYCLES_O,
   output logic      [4:0]  FLAGS_O,
   output logic      [7:0]  LATCH_O
);
   // ============================================================
   // class of a single word, from the opcode bits only
   function automatic opdec_pkg::op_class_t class_of(input logic [15:0] w);
      opdec_pkg::op_class_t c;
      c = opdec_pkg::CL_BYTE;
      case (w[15:12])
         4'h0: begin
            if (w[11])
               c = opdec_pkg::CL_LIT;
            else if (w[11:8] == 4'h1)
               c = opdec_pkg::CL_BANK;
            else if (w[11:8] != 4'h0)
               c = opdec_pkg::CL_BYTE;
            else if (w[7:3] == 5'h01)
               c = opdec_pkg::CL_TABLE;
            else if (w[7:1] == 7'h08 || w[7:1] == 7'h09)
               c = opdec_pkg::CL_RET;
            else
               c = opdec_pkg::CL_NOP;
         end
         4'h7, 4'h8, 4'h9, 4'hA, 4'hB: c = opdec_pkg::CL_BIT;
         4'hC: c = opdec_pkg::CL_MOVE;
         4'hD: c = opdec_pkg::CL_BRREL;
         4'hE: begin
            if (!w[11])
               c = opdec_pkg::CL_BRREL;
            else if (w[10:9] == 2'h2)
               c = opdec_pkg::CL_BRABS;
            else if (w[10:8] == 3'h6)
               c = opdec_pkg::CL_LFSR;
            else if (w[10:8] == 3'h7)
               c = opdec_pkg::CL_BRABS;
            else if (w[10:8] == 3'h3)
               c = opdec_pkg::CL_INDEX;
            else
               c = opdec_pkg::CL_LIT;
         end
         4'hF: c = opdec_pkg::CL_NOP;
         default: c = opdec_pkg::CL_BYTE;
      endcase
      return c;
   endfunction : class_of

   // ============================================================
   // state
   logic [1:0]  phase_q;
   logic [3:0]  bank_q;
   logic [4:0]  flags_q;
   logic [20:0] tptr_q;
   logic [7:0]  latch_q;
   logic [15:0] first_q;
   opdec_pkg::pend_t pend_q;
   opdec_pkg::pend_t pend_d;

   // ============================================================
   // instruction cycle: one decode slot every four clocks
   wire ph_last  = (phase_q == opdec_pkg::PH_LAST);
   wire dec_fire = ph_last & INSTR_VALID_I;
   wire [3:0] nib = INSTR_I[15:12];
   opdec_pkg::op_class_t cls;
   assign cls = class_of(INSTR_I);
   // a word with the second-word prefix only completes a pending pair
   wire is_second = (nib == opdec_pkg::NIB_SECOND);
   wire completes = is_second & (pend_q != opdec_pkg::PD_NONE);

   // next pair state; a first word of a pair raises no valid yet
   always_comb begin
      pend_d = opdec_pkg::PD_NONE;
      if (!completes) begin
         case (cls)
            opdec_pkg::CL_MOVE:  pend_d = opdec_pkg::PD_MOVE;
            opdec_pkg::CL_BRABS: pend_d = opdec_pkg::PD_LONG;
            opdec_pkg::CL_LFSR:  pend_d = opdec_pkg::PD_LFSR;
            opdec_pkg::CL_INDEX: pend_d = opdec_pkg::PD_IDX;
            default:             pend_d = opdec_pkg::PD_NONE;
         endcase
      end
   end
   wire starts_pair = (pend_d != opdec_pkg::PD_NONE);

   // ============================================================
   // field extraction; bits outside the fields are never looked at
   // RQ14 dont care ignored
   wire [7:0] f_fld = INSTR_I[7:0];
   // RQ1 access region
   wire [3:0] acc_bank = (f_fld < ACCESS_SPLIT) ?
                         opdec_pkg::ACC_LO_BANK : opdec_pkg::ACC_HI_BANK;
   // RQ2 banked address
   wire [3:0] use_bank = INSTR_I[8] ? bank_q : acc_bank;
   wire [11:0] file_adr = {use_bank, f_fld};
   wire cls_file = (cls == opdec_pkg::CL_BYTE) | (cls == opdec_pkg::CL_BIT);

   // RQ13 relative offset, short form sign extended to eleven bits
   wire [10:0] rel_off = (nib == 4'hD) ? INSTR_I[10:0] :
                         {{3{INSTR_I[7]}}, INSTR_I[7:0]};
   // RQ9 shadow select sits in bit 8 for call, bit 0 for return
   wire shadow = (cls == opdec_pkg::CL_RET) ? INSTR_I[0] :
                 (cls == opdec_pkg::CL_BRABS) & ~INSTR_I[8] ? 1'b0 :
                 (cls == opdec_pkg::CL_BRABS) & INSTR_I[9] & ~INSTR_I[8] ?
                 1'b0 : INSTR_I[8] & ~INSTR_I[9];

   // RQ11 table pointer mode
   wire [1:0] tmode = INSTR_I[1:0];
   wire tbl_op = dec_fire & (cls == opdec_pkg::CL_TABLE) & ~completes;
   wire [20:0] tptr_inc = tptr_q + opdec_pkg::TPTR_ONE;
   wire [20:0] tptr_dec = tptr_q - opdec_pkg::TPTR_ONE;
   wire [20:0] tptr_hw  = (tmode == opdec_pkg::TM_POSTINC) ? tptr_inc :
                          (tmode == opdec_pkg::TM_POSTDEC) ? tptr_dec :
                          (tmode == opdec_pkg::TM_PREINC)  ? tptr_inc :
                          tptr_q;
   wire [20:0] tbl_adr  = (tmode == opdec_pkg::TM_PREINC) ? tptr_inc : tptr_q;

   // ============================================================
   // APB decode; zero wait state, unmapped reads zero with an error
   wire apb_setup = PSEL_I & ~PENABLE_I;
   wire apb_wr    = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
   wire hit_bank  = (PADDR_I == opdec_pkg::ADR_BANK);
   wire hit_flags = (PADDR_I == opdec_pkg::ADR_FLAGS);
   wire hit_tptr  = (PADDR_I == opdec_pkg::ADR_TPTR);
   wire hit_latch = (PADDR_I == opdec_pkg::ADR_LATCH);
   wire hit_stat  = (PADDR_I == opdec_pkg::ADR_STAT);
   wire hit_any   = hit_bank | hit_flags | hit_tptr | hit_latch | hit_stat;
   wire [31:0] rd_mux = hit_bank  ? {28'h0000000, bank_q} :
                        hit_flags ? {27'h0000000, flags_q} :
                        hit_tptr  ? {11'h000, tptr_q} :
                        hit_latch ? {24'h000000, latch_q} :
                        hit_stat  ? {25'h0000000, pend_q, OP_CLASS_O} :
                        32'h00000000;

   // bus answer registered in the setup cycle, so it stands in access
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
      end else begin
         PREADY_O  <= apb_setup;
         PSLVERR_O <= apb_setup & ~hit_any;
         PRDATA_O  <= (apb_setup & ~PWRITE_I) ? rd_mux : 32'h00000000;
      end
   end

   // ============================================================
   // bank register: software or a bank literal instruction loads it
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I)
         bank_q <= 4'h0;
      else if (dec_fire & ~completes & (cls == opdec_pkg::CL_BANK))
         bank_q <= INSTR_I[3:0];
      else if (apb_wr & hit_bank)
         bank_q <= PWDATA_I[3:0];
   end

   // RQ8 status flags, datapath update wins per bit over software
   wire [4:0] flags_sw = (apb_wr & hit_flags) ? PWDATA_I[4:0] : flags_q;
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I)
         flags_q <= 5'h00;
      else
         flags_q <= (flags_sw & ~FLAG_UPD_I) | (FLAG_VAL_I & FLAG_UPD_I);
   end

   // RQ10 table pointer and latch; the table instruction and LATCH_WE_I win over software
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         tptr_q  <= 21'h000000;
         latch_q <= 8'h00;
      end else begin
         if (tbl_op)
            tptr_q <= tptr_hw;
         else if (apb_wr & hit_tptr)
            tptr_q <= PWDATA_I[20:0];
         if (LATCH_WE_I)
            latch_q <= LATCH_D_I;
         else if (apb_wr & hit_latch)
            latch_q <= PWDATA_I[7:0];
      end
   end

   // RQ17 four clock phases per instruction cycle
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I)
         phase_q <= 2'h0;
      else
         phase_q <= phase_q + 2'h1;
   end

   // pair bookkeeping; a stray word resets the pair to a new start
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         pend_q  <= opdec_pkg::PD_NONE;
         first_q <= 16'h0000;
      end else if (dec_fire) begin
         pend_q  <= pend_d;
         first_q <= INSTR_I;
      end
   end

   // ============================================================
   // output register: every field loads at the same edge as the class
   // RQ18 fields with class
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         DEC_VALID_O   <= 1'b0;
         OP_CLASS_O    <= 4'h0;
         DATA_ADDR_O   <= 12'h000;
         DEST_FILE_O   <= 1'b0;
         BIT_INDEX_O   <= 3'h0;
         PTR_SEL_O     <= 2'h0;
         MOVE_SRC_O    <= 12'h000;
         MOVE_DST_O    <= 12'h000;
         LITERAL_O     <= 20'h00000;
         BRANCH_OFF_O  <= 11'h000;
         FAST_SHADOW_O <= 1'b0;
         SRC_IDX_O     <= 7'h00;
         DST_IDX_O     <= 7'h00;
         TBL_ADDR_O    <= 21'h000000;
         TBL_WRITE_O   <= 1'b0;
         EXEC_CYCLES_O <= 2'h0;
      end else if (dec_fire & completes) begin
         DEC_VALID_O   <= 1'b1;
         OP_CLASS_O    <= class_of(first_q);
         EXEC_CYCLES_O <= opdec_pkg::CYC_TWO;
         // RQ6 move source full address
         MOVE_SRC_O    <= first_q[11:0];
         // RQ7 move destination full address
         MOVE_DST_O    <= INSTR_I[11:0];
         // RQ12 twenty or twelve bit literal
         LITERAL_O     <= (pend_q == opdec_pkg::PD_LFSR) ?
                          {8'h00, first_q[3:0], INSTR_I[7:0]} :
                          {INSTR_I[11:0], first_q[7:0]};
         // RQ5 pointer designator
         PTR_SEL_O     <= first_q[5:4];
         // RQ15 index offsets
         SRC_IDX_O     <= first_q[6:0];
         DST_IDX_O     <= INSTR_I[6:0];
         FAST_SHADOW_O <= (class_of(first_q) == opdec_pkg::CL_BRABS) &
                          ~first_q[9] & first_q[8];
      end else if (dec_fire & ~starts_pair) begin
         DEC_VALID_O   <= 1'b1;
         // RQ16 lone second word
         OP_CLASS_O    <= is_second ? opdec_pkg::CL_NOP : cls;
         // RQ5 eight bit file address
         DATA_ADDR_O   <= cls_file ? file_adr : 12'h000;
         // RQ4 destination select
         DEST_FILE_O   <= INSTR_I[9];
         // RQ3 bit number
         BIT_INDEX_O   <= INSTR_I[11:9];
         // RQ12 eight bit literal
         LITERAL_O     <= {12'h000, INSTR_I[7:0]};
         // RQ13 relative displacement
         BRANCH_OFF_O  <= rel_off;
         // RQ9 shadow select
         FAST_SHADOW_O <= (cls == opdec_pkg::CL_RET) & shadow;
         TBL_ADDR_O    <= (cls == opdec_pkg::CL_TABLE) ? tbl_adr : TBL_ADDR_O;
         TBL_WRITE_O   <= (cls == opdec_pkg::CL_TABLE) & INSTR_I[2];
         // RQ17 program counter change costs a second cycle
         EXEC_CYCLES_O <= (cls == opdec_pkg::CL_BRREL ||
                           cls == opdec_pkg::CL_RET) ?
                          opdec_pkg::CYC_TWO : opdec_pkg::CYC_ONE;
      end else begin
         DEC_VALID_O   <= 1'b0;
      end
   end

   assign FLAGS_O = flags_q;
   assign LATCH_O = latch_q;

   // ============================================================
   // checks
   wire sgl = dec_fire & ~starts_pair & ~completes;

   AST_ACCESS_REGION: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ1
      sgl && cls_file && !INSTR_I[8] |=> DATA_ADDR_O[11:8] ==
      (($past(INSTR_I[7:0]) < ACCESS_SPLIT) ? 4'h0 : 4'hF))
      else $error("access region address wrong");
   AST_BANKED: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ2
      sgl && cls_file && INSTR_I[8] |=> DATA_ADDR_O == {$past(bank_q), $past(INSTR_I[7:0])})
      else $error("banked address wrong");
   AST_BIT_INDEX: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ3
      sgl && cls == opdec_pkg::CL_BIT |=> BIT_INDEX_O == $past(INSTR_I[11:9]))
      else $error("bit index wrong");
   AST_DEST: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ4
      sgl && cls == opdec_pkg::CL_BYTE |=> DEST_FILE_O == $past(INSTR_I[9]))
      else $error("destination select wrong");
   AST_MOVE_PAIR: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ7
      dec_fire && completes && pend_q == opdec_pkg::PD_MOVE |=>
      DEC_VALID_O && MOVE_DST_O == $past(INSTR_I[11:0]) && MOVE_SRC_O == $past(first_q[11:0]))
      else $error("move addresses wrong");
   AST_TBL_POSTINC: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ11
      tbl_op && tmode == opdec_pkg::TM_POSTINC |=> tptr_q == $past(tptr_q) + 21'h000001
      && TBL_ADDR_O == $past(tptr_q))
      else $error("table post increment wrong");
   AST_LONE_SECOND: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ16
      dec_fire && is_second && pend_q == opdec_pkg::PD_NONE |=> OP_CLASS_O == 4'h0)
      else $error("lone second word not a no-operation");
   AST_CYCLE_GAP: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ17
      DEC_VALID_O |=> !DEC_VALID_O [*3])
      else $error("decode slots closer than four clocks");
   AST_SHADOW: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RQ9
      sgl && cls == opdec_pkg::CL_RET |=> FAST_SHADOW_O == $past(INSTR_I[0]))
      else $error("shadow select wrong");
   AST_APB_READY: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      apb_setup |=> PREADY_O ##1 !PREADY_O)
      else $error("bus answer not in access cycle");
endmodule : operand_field_decoder
`default_nettype wire

// [rtl/opdec_pkg.sv]
// constants, field layout and types for the operand field decoder
// assumes one core clock; fetch and datapath sit on the same clock
// Operation
// RQ1: ram select 0 addresses fixed access region, bank register ignored
// RQ2: ram select 1 joins bank register with the 8-bit file address
// RQ3: bit field gives bit 0 to 7 of addressed file register
// RQ4: destination select 0 means working register, 1 means file register
// RQ5: file field is 8-bit address or 2-bit indirect pointer designator
// RQ6: move source is a full 12-bit address, no bank selection
// RQ7: move destination is a full 12-bit address for the write
// RQ8: keep carry, digit carry, zero, overflow and negative flags
// RQ9: fast shadow select 1 uses shadow registers on call/return, 0 not
// RQ10: hold 21-bit program table pointer and 8-bit table latch byte
// RQ11: table pointer unchanged, post-inc, post-dec or pre-inc per mode
// RQ12: literal is 8, 12 or 20 bits per instruction format
// RQ13: branch field relative two's complement or absolute address
// RQ14: don't care bits are ignored; generators should emit zero
// RQ15: indexed addressing uses 7-bit source and destination offsets
// RQ16: lone second word of a two-word instruction runs as no-operation
// RQ17: instruction cycle is four clocks; branches and pairs take two
// RQ18: all fields appear together with the class, no extra cycle
package opdec_pkg;
   // ============================================================
   // register map, byte addresses
   localparam logic [7:0] ADR_BANK  = 8'h00;
   localparam logic [7:0] ADR_FLAGS = 8'h04;
   localparam logic [7:0] ADR_TPTR  = 8'h08;
   localparam logic [7:0] ADR_LATCH = 8'h0C;
   localparam logic [7:0] ADR_STAT  = 8'h10;
   // ============================================================
   // field constants
   localparam logic [3:0] NIB_SECOND  = 4'hF;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [1:0] TM_NONE     = 2'h0;
   localparam logic [1:0] TM_POSTINC  = 2'h1;
   localparam logic [1:0] TM_POSTDEC  = 2'h2;
   localparam logic [1:0] TM_PREINC   = 2'h3;
   localparam logic [1:0] PH_LAST     = 2'h3;
   localparam logic [1:0] CYC_ONE     = 2'h1;
   localparam logic [1:0] CYC_TWO     = 2'h2;
   localparam logic [20:0] TPTR_ONE   = 21'h000001;
   // ============================================================
   // types
   typedef enum logic [3:0] {
      CL_NOP, CL_BYTE, CL_BIT, CL_LIT, CL_BANK, CL_MOVE, CL_BRREL,
      CL_BRABS, CL_RET, CL_TABLE, CL_LFSR, CL_INDEX
   } op_class_t;
   typedef enum logic [2:0] {
      PD_NONE, PD_MOVE, PD_LONG, PD_LFSR, PD_IDX
   } pend_t;
endpackage : opdec_pkg

// [tb/fetch_model.sv]
// fetch-side partner: offers queued instruction words on decode slots
// assumes the decoder takes a word on every 4th edge after reset release
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   output logic      [15:0] instr_o,
   output logic             valid_o
);
   // ============================================================
   // word queue, filled by the bench
   logic [15:0] q[$];
   logic [1:0]  edge_q;
   // one word per four clocks
   // the word is held only through its slot edge, then the bus turns to junk
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         edge_q  <= 2'h0;
         valid_o <= 1'b0;
         instr_o <= 16'h0000;
      end else begin
         edge_q <= edge_q + 2'h1;
         if (edge_q == 2'h2 && q.size() > 0) begin
            instr_o <= q.pop_front();
            valid_o <= 1'b1;
         end else begin
            valid_o <= 1'b0;
            instr_o <= ~instr_o;
         end
      end
   end
endmodule : fetch_model
`default_nettype wire

// [tb/tb_operand_field_decoder.sv]
// bench for the operand field decoder: apb master, fetch model, checks
// assumes the hand-over timing: zero-wait apb, decode valid after a slot
`timescale 1ns/1ns
`default_nettype none
module tb_operand_field_decoder;
   // ============================================================
   // signals
   typedef struct {logic [3:0] c; logic [2:0] k; logic [31:0] v; logic [1:0] n;} exp_t;
   logic CLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, LATCH_WE_I;
   logic [7:0] PADDR_I, LATCH_D_I;
   logic [31:0] PWDATA_I, PRDATA_O;
   logic [4:0] FLAG_UPD_I, FLAG_VAL_I, FLAGS_O;
   wire logic [15:0] INSTR_I;
   wire logic INSTR_VALID_I;
   logic PREADY_O, PSLVERR_O, DEC_VALID_O, DEST_FILE_O, FAST_SHADOW_O, TBL_WRITE_O;
   logic [3:0] OP_CLASS_O;
   logic [11:0] DATA_ADDR_O, MOVE_SRC_O, MOVE_DST_O;
   logic [2:0] BIT_INDEX_O;
   logic [1:0] PTR_SEL_O, EXEC_CYCLES_O;
   logic [19:0] LITERAL_O;
   logic [10:0] BRANCH_OFF_O;
   logic [6:0] SRC_IDX_O, DST_IDX_O;
   logic [20:0] TBL_ADDR_O, p;
   logic [7:0] LATCH_O, f;
   exp_t exq[$];
   exp_t cur;
   int errors = 0;
   int checks_done = 0;
   int seed_v;
   logic [31:0] r, m, v;
   logic [3:0] bk;
   logic ab, db;
   logic [3:0] bops[5] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
   logic [15:0] bw[4] = '{16'hD7FF, 16'hD400, 16'hE280, 16'hE27F};
   logic [10:0] bo[4] = '{11'h7FF, 11'h400, 11'h780, 11'h07F};
   operand_field_decoder dut (.CLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
      .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .INSTR_I, .INSTR_VALID_I,
      .FLAG_UPD_I, .FLAG_VAL_I, .LATCH_WE_I, .LATCH_D_I, .DEC_VALID_O, .OP_CLASS_O,
      .DATA_ADDR_O, .DEST_FILE_O, .BIT_INDEX_O, .PTR_SEL_O, .MOVE_SRC_O, .MOVE_DST_O,
      .LITERAL_O, .BRANCH_OFF_O, .FAST_SHADOW_O, .SRC_IDX_O, .DST_IDX_O, .TBL_ADDR_O,
      .TBL_WRITE_O, .EXEC_CYCLES_O, .FLAGS_O, .LATCH_O);
   fetch_model fm (.clk_i(CLK_I), .rst_b_i(RST_B_I), .instr_o(INSTR_I),
      .valid_o(INSTR_VALID_I));
   // ============================================================
   // helpers
   task fail(input string s);
      errors++;
      $display("CHECK FAILED %0t %s", $time, s);
   endtask : fail
   task give_verdict;
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // one output group per kind; kind 7 compares class and cycles only
   function automatic logic [31:0] pick(input logic [2:0] k);
      case (k)
         3'h0: pick = {19'h0, DEST_FILE_O, DATA_ADDR_O};
         3'h1: pick = {17'h0, BIT_INDEX_O, DATA_ADDR_O};
         3'h2: pick = {MOVE_SRC_O, MOVE_DST_O, 8'h00};
         3'h3: pick = {11'h0, FAST_SHADOW_O, LITERAL_O};
         3'h4: pick = {21'h0, BRANCH_OFF_O};
         3'h5: pick = {10'h0, PTR_SEL_O, LITERAL_O};
         3'h6: pick = {10'h0, TBL_WRITE_O, TBL_ADDR_O};
         default: pick = 32'h0;
      endcase
   endfunction : pick
   // apb master: holds the request until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] x, input logic er);
      int i;
      @(posedge CLK_I);
      PSEL_I    <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I  <= w;
      PADDR_I   <= a;
      PWDATA_I  <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      i = 0;
      do begin
         @(posedge CLK_I);
         i++;
      end while (PREADY_O !== 1'b1 && i < 20);
      if (i >= 20) begin
         fail("apb timeout");
         give_verdict();
      end else begin
         checks_done++;
         if (PSLVERR_O !== er || (!w && PRDATA_O !== x)) fail("apb mismatch");
         PSEL_I    <= 1'b0;
         PENABLE_I <= 1'b0;
      end
   endtask : apb
   task send(input logic [15:0] w);
      int i;
      fm.q.push_back(w);
      i = 0;
      while (fm.q.size() != 0 && i < 40) begin
         @(posedge CLK_I);
         i++;
      end
      if (i >= 40) begin
         fail("fetch timeout");
         give_verdict();
      end else
         repeat (3) @(posedge CLK_I);
   endtask : send
   // the push lands off the edge so the monitor never races it
   task dec(input logic [15:0] w, input logic [3:0] c, input logic [2:0] k,
            input logic [31:0] x, input logic [1:0] n);
      #1 exq.push_back('{c, k, x, n});
      send(w);
   endtask : dec
   // ============================================================
   // monitor: oldest note against each decode pulse
   always @(posedge CLK_I) begin
      if (DEC_VALID_O === 1'b1) begin
         if (exq.size() == 0)
            fail("unexpected decode");
         else begin
            cur = exq.pop_front();
            checks_done++;
            if (OP_CLASS_O !== cur.c || pick(cur.k) !== cur.v) fail("field mismatch");
            if (EXEC_CYCLES_O !== cur.n) fail("cycle count mismatch");
         end
      end
   end
   initial begin
      CLK_I = 1'b0;
      forever #25 CLK_I = ~CLK_I;
   end
   // ============================================================
   // main sequence
   initial begin
      {RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, LATCH_WE_I} = 5'h00;
      {PADDR_I, LATCH_D_I, PWDATA_I, FLAG_UPD_I, FLAG_VAL_I} = 58'h0;
      seed_v = $urandom(55);
      repeat (10) @(posedge CLK_I);
      RST_B_I <= 1'b1;
      for (int i = 0; i < 5; i++) apb(1'b0, 8'(4 * i), 32'h0, 32'h0, 1'b0);
      apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
      apb(1'b1, opdec_pkg::ADR_BANK, 32'h5, 32'h0, 1'b0);
      dec(16'h2612, opdec_pkg::CL_BYTE, 3'h0, 32'h1012, 2'h1);
      dec(16'h2712, opdec_pkg::CL_BYTE, 3'h0, 32'h1512, 2'h1);
      dec(16'h2470, opdec_pkg::CL_BYTE, 3'h0, 32'h0F70, 2'h1);
      dec(16'h0103, opdec_pkg::CL_BANK, 3'h7, 32'h0, 2'h1);
      apb(1'b0, opdec_pkg::ADR_BANK, 32'h0, 32'h3, 1'b0);
      for (int b = 0; b < 8; b++)
         dec({bops[b % 5], 3'(b), 1'b1, 8'(b)}, opdec_pkg::CL_BIT, 3'h1,
             {17'h0, 3'(b), 9'h060, 3'(b)}, 2'h1);
      dec(16'h0E7F, opdec_pkg::CL_LIT, 3'h3, 32'h7F, 2'h1);
      for (int i = 0; i < 4; i++)
         dec(bw[i], opdec_pkg::CL_BRREL, 3'h4, {21'h0, bo[i]}, 2'h2);
      send(16'hEF34);
      dec(16'hF12A, opdec_pkg::CL_BRABS, 3'h3, 32'h00012A34, 2'h2);
      send(16'hED56);
      dec(16'hF789, opdec_pkg::CL_BRABS, 3'h3, 32'h00178956, 2'h2);
      send(16'hC123);
      dec(16'hFABC, opdec_pkg::CL_MOVE, 3'h2, 32'h123ABC00, 2'h2);
      send(16'hC555);
      dec(16'h2612, opdec_pkg::CL_BYTE, 3'h0, 32'h1012, 2'h1);
      dec(16'hF123, opdec_pkg::CL_NOP, 3'h7, 32'h0, 2'h1);
      send(16'hEE2A);
      dec(16'hF0BC, opdec_pkg::CL_LFSR, 3'h5, 32'h00200ABC, 2'h2);
      send(16'hEB05);
      dec(16'hF123, opdec_pkg::CL_INDEX, 3'h7, 32'h0, 2'h2);
      checks_done++;
      if (SRC_IDX_O !== 7'h05 || DST_IDX_O !== 7'h23) fail("index offset mismatch");
      for (int i = 0; i < 4; i++) begin
         dec(16'h0010 | 16'(i), opdec_pkg::CL_RET, 3'h7, 32'h0, 2'h2);
         checks_done++;
         if (FAST_SHADOW_O !== 1'(i)) fail("shadow select mismatch");
      end
      // all four pointer modes, from the top of the range
      p = 21'h1FFFFF;
      apb(1'b1, opdec_pkg::ADR_TPTR, {11'h0, p}, 32'h0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         dec(16'h0008 + 16'(i), opdec_pkg::CL_TABLE, 3'h6,
             {10'h0, 1'(i >> 2), (i % 4 == 3) ? p + 21'h1 : p}, 2'h1);
         p = (i % 4 == 1 || i % 4 == 3) ? p + 21'h1 : (i % 4 == 2) ? p - 21'h1 : p;
         apb(1'b0, opdec_pkg::ADR_TPTR, 32'h0, {11'h0, p}, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         r = $urandom & 32'h1F;
         m = $urandom & 32'h1F;
         v = $urandom & 32'h1F;
         apb(1'b1, opdec_pkg::ADR_FLAGS, r, 32'h0, 1'b0);
         FLAG_UPD_I <= m[4:0];
         FLAG_VAL_I <= v[4:0];
         @(posedge CLK_I);
         FLAG_UPD_I <= 5'h00;
         apb(1'b0, opdec_pkg::ADR_FLAGS, 32'h0, (r & ~m) | (v & m), 1'b0);
         checks_done++;
         if (FLAGS_O !== ((r[4:0] & ~m[4:0]) | (v[4:0] & m[4:0]))) fail("flags mismatch");
      end
      r = $urandom & 32'hFF;
      LATCH_WE_I <= 1'b1;
      LATCH_D_I  <= r[7:0];
      @(posedge CLK_I);
      LATCH_WE_I <= 1'b0;
      apb(1'b0, opdec_pkg::ADR_LATCH, 32'h0, r, 1'b0);
      checks_done++;
      if (LATCH_O !== r[7:0]) fail("latch mismatch");
      apb(1'b1, opdec_pkg::ADR_LATCH, ~r & 32'hFF, 32'h0, 1'b0);
      apb(1'b0, opdec_pkg::ADR_LATCH, 32'h0, ~r & 32'hFF, 1'b0);
      for (int i = 0; i < 12; i++) begin
         {bk, ab, db, f} = 14'($urandom);
         apb(1'b1, opdec_pkg::ADR_BANK, {28'h0, bk}, 32'h0, 1'b0);
         dec({6'b001001, db, ab, f}, opdec_pkg::CL_BYTE, 3'h0, {19'h0, db,
             ab ? bk : (f < 8'h60) ? opdec_pkg::ACC_LO_BANK : opdec_pkg::ACC_HI_BANK,
             f}, 2'h1);
      end
      repeat (8) @(posedge CLK_I);
      if (exq.size() != 0) fail("decode missing");
      give_verdict();
   end
endmodule : tb_operand_field_decoder
`default_nettype wire
